// [rtl/pcwd_pkg.sv]
/*
 * Shared constants and carrier types for the pad command word dispatcher.
 * Assumes a single 125 MHz system clock and a serial link delivering
 * duplicated 24-bit command words with a bit strobe and a frame level.
 */
package pcwd_pkg;

    // System clock rate
    localparam int unsigned CLK_HZ          = 125_000_000;

    // Command word framing
    localparam int unsigned WORD_W          = 24;
    localparam int unsigned BIT_CNT_W       = 5;
    localparam logic [4:0]  LAST_BIT        = 5'h17;

    // Destination field, top two bits of the word
    localparam int unsigned DEST_W          = 2;
    localparam int unsigned PAYLOAD_W       = 22;
    localparam logic [1:0]  DEST_LOADER     = 2'h0;
    localparam logic [1:0]  DEST_POWER      = 2'h1;
    localparam logic [1:0]  DEST_CONTROL    = 2'h2;

    // Power unit payload fields
    localparam int unsigned PWR_OP_BIT      = 21;
    localparam int unsigned PWR_VOLT_W      = 12;
    localparam int unsigned PWR_SW_W        = 8;
    localparam int unsigned PWR_SW_ON_BIT   = 8;
    localparam logic [11:0] PWR_VOLT_RST    = 12'h000;
    localparam logic [7:0]  PWR_SW_RST      = 8'h00;

    // Control unit payload fields
    localparam int unsigned CTL_RELAYS      = 32;
    localparam int unsigned CTL_STATE_BIT   = 5;

    // Sequencer loading bit rate and derived bit time
    localparam int unsigned SEQ_BIT_RATE_BPS = 250;
    localparam int unsigned SEQ_BIT_CYCLES   = CLK_HZ / SEQ_BIT_RATE_BPS;

    // Suggested link bit rate band, far below what the sampler can follow
    localparam int unsigned LINK_RATE_MIN_BPS = 50_000;
    localparam int unsigned LINK_RATE_MAX_BPS = 150_000;

    // Decoded command word
    typedef struct packed
    {
        logic [DEST_W-1:0]    dest;
        logic [PAYLOAD_W-1:0] payload;
    } pcwd_cmd_t;

    // Confirmation sent back to the remote test complex
    typedef struct packed
    {
        logic      valid;
        pcwd_cmd_t word;
    } pcwd_confirm_t;

    // Receiver phases
    typedef enum logic [1:0]
    {
        RX_HUNT,
        RX_COPY1,
        RX_COPY2,
        RX_DONE
    } pcwd_rx_t;

endpackage

// [rtl/pcwd_seq_loader.sv]
/*
 * Sequencer loading unit: holds one command word and clocks it serially,
 * MSB first, into the spacecraft sequencer storage at the slow bit rate.
 * Assumes the caller holds an offered word until ready_o is high.
 */
`timescale 1ns/1ns
module pcwd_seq_loader
#(
    parameter int unsigned BIT_CYCLES = pcwd_pkg::SEQ_BIT_CYCLES
)
(
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              load_valid_i,
    input  pcwd_pkg::pcwd_cmd_t    load_word_i,
    output logic                   ready_o,
    output logic                   seq_clk_o,
    output logic                   seq_data_o,
    output logic                   done_o,
    output pcwd_pkg::pcwd_cmd_t    done_word_o
);
    import pcwd_pkg::*;

    localparam int unsigned HALF = (BIT_CYCLES / 2 < 1) ? 1 : BIT_CYCLES / 2;
    localparam logic [31:0] HALF_LAST = 32'(HALF - 1);

    // All loader state
    typedef struct packed
    {
        logic            busy;      // Word being shifted
        logic [31:0]     tick;      // Cycles within a half bit
        logic [4:0]      bits;      // Bits already sent
        logic [23:0]     shreg;     // Remaining bits, MSB out
        pcwd_cmd_t       word;      // Copy for confirmation
        logic            sclk;      // Sequencer clock level
        logic            sdat;      // Sequencer data level
        logic            done;      // Word finished pulse
    } pcwd_ld_state_t;

    pcwd_ld_state_t st_reg;
    pcwd_ld_state_t st_next;

    // Next-state logic for the shifter
    always_comb
    begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (!st_reg.busy)
        begin
            // Take a new word, present its first bit
            if (load_valid_i)
            begin
                st_next.busy  = 1'b1;
                st_next.word  = load_word_i;
                st_next.shreg = load_word_i;
                st_next.sdat  = load_word_i.dest[1];
                st_next.sclk  = 1'b0;
                st_next.tick  = 32'h0;
                st_next.bits  = 5'h00;
            end
        end
        else if (st_reg.tick != HALF_LAST)
        begin
            // Wait out the half bit
            st_next.tick = st_reg.tick + 32'h1;
        end
        else
        begin
            st_next.tick = 32'h0;
            if (!st_reg.sclk)
            begin
                // Rising edge, sequencer samples the data
                st_next.sclk = 1'b1;
            end
            else
            begin
                // Falling edge, advance to the next bit
                st_next.sclk  = 1'b0;
                st_next.shreg = {st_reg.shreg[22:0], 1'b0};
                st_next.sdat  = st_reg.shreg[22];
                st_next.bits  = st_reg.bits + 5'h01;
                if (st_reg.bits == LAST_BIT)
                begin
                    st_next.busy = 1'b0;
                    st_next.sdat = 1'b0;
                    st_next.done = 1'b1;
                end
            end
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign ready_o     = !st_reg.busy;
    assign seq_clk_o   = st_reg.sclk;
    assign seq_data_o  = st_reg.sdat;
    assign done_o      = st_reg.done;
    assign done_word_o = st_reg.word;

endmodule

// [rtl/pcwd_dispatcher.sv]
/*
 * Pad command word dispatcher: receives duplicated 24-bit command words
 * from the remote test complex, verifies the copies, routes each verified word to
 * the sequencer loader, power unit or control unit or refuses it, and confirms execution.
 * Assumes the link modem gives data, a bit strobe and a frame level, all
 * asynchronous to clk_i and much slower than it.
 */
// Operation
// - Link words are fixed 24-bit frames.
// - Each word sent twice; compare before execution.
// - Verified word goes to at most one unit; unassigned dest or loader word while one waits is refused.
// - Loader stores word, shifts out at 250 bps.
// - Power words adjust voltage or switch supplies.
// - Control words become discrete relay outputs.
// - Every executed command returns a confirmation.
// - Link bit rate suggested 50 to 150 kbps.
`timescale 1ns/1ns
module pcwd_dispatcher
#(
    parameter int unsigned SEQ_BIT_CYCLES = pcwd_pkg::SEQ_BIT_CYCLES,
    parameter int unsigned NUM_RELAYS     = pcwd_pkg::CTL_RELAYS
)
(
    input  wire logic                             clk_i,
    input  wire logic                             rst_n_i,
    input  wire logic                             link_data_i,
    input  wire logic                             link_strobe_i,
    input  wire logic                             link_frame_i,
    output logic                                  seq_clk_o,
    output logic                                  seq_data_o,
    output logic [pcwd_pkg::PWR_VOLT_W-1:0]       power_volt_o,
    output logic [pcwd_pkg::PWR_SW_W-1:0]         power_switch_o,
    output logic [NUM_RELAYS-1:0]                 relay_o,
    output pcwd_pkg::pcwd_confirm_t               confirm_o,
    output logic                                  mismatch_o,
    output logic                                  reject_o
);
    import pcwd_pkg::*;

    localparam int unsigned IDX_W = (NUM_RELAYS > 1) ? $clog2(NUM_RELAYS) : 1;

    // All dispatcher state
    typedef struct packed
    {
        logic [2:0]              sync1;     // Pin sampler stage one
        logic [2:0]              sync2;     // Pin sampler stage two
        logic                    strb_prev; // Strobe level last cycle
        pcwd_rx_t                rx;        // Receiver phase
        logic [BIT_CNT_W-1:0]    cnt;       // Bits in current copy
        logic [WORD_W-1:0]       first;     // First copy
        logic [WORD_W-1:0]       second;    // Second copy in progress
        logic                    pend_v;    // Loader word waiting
        pcwd_cmd_t               pend;      // Waiting loader word
        logic                    ldc_v;     // Loader confirmation owed
        pcwd_cmd_t               ldc;       // Word owed a confirmation
        logic [PWR_VOLT_W-1:0]   volt;      // Voltage adjust level
        logic [PWR_SW_W-1:0]     sw;        // Supply switch states
        logic [NUM_RELAYS-1:0]   relay;     // Relay discretes
        pcwd_confirm_t           conf;      // Confirmation pulse
        logic                    mism;      // Mismatch pulse
        logic                    rej;       // Reject pulse
    } pcwd_state_t;

    pcwd_state_t st_reg;
    pcwd_state_t st_next;

    // Loader handshake
    logic        ld_ready;
    logic        ld_done;
    pcwd_cmd_t   ld_done_word;

    // Sequencer loading unit
    pcwd_seq_loader
    #(
        .BIT_CYCLES   (SEQ_BIT_CYCLES)
    )
    u_loader
    (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_i),
        .load_valid_i (st_reg.pend_v),
        .load_word_i  (st_reg.pend),
        .ready_o      (ld_ready),
        .seq_clk_o    (seq_clk_o),
        .seq_data_o   (seq_data_o),
        .done_o       (ld_done),
        .done_word_o  (ld_done_word)
    );

    // Apply a supply switching command
    function automatic logic [PWR_SW_W-1:0] switch_apply(input logic [PWR_SW_W-1:0] cur,
                                                         input logic [PAYLOAD_W-1:0] pl);
        logic [PWR_SW_W-1:0] mask;
        mask = pl[PWR_SW_W-1:0];
        if (pl[PWR_SW_ON_BIT])
            switch_apply = cur | mask;
        else
            switch_apply = cur & ~mask;
    endfunction

    // Next-state logic: sampling, framing, verify, dispatch, confirm
    always_comb
    begin
        logic       bit_rise;
        logic       frame;
        logic       din;
        logic       verify;
        logic       exec_conf;
        logic [WORD_W-1:0] full2;
        pcwd_cmd_t  w;
        logic [IDX_W-1:0] idx;
        bit_rise  = 1'b0;
        frame     = 1'b0;
        din       = 1'b0;
        verify    = 1'b0;
        exec_conf = 1'b0;
        full2     = '0;
        w         = '0;
        idx       = '0;

        st_next          = st_reg;
        st_next.conf     = '0;
        st_next.mism     = 1'b0;
        st_next.rej      = 1'b0;

        // Two-stage sampling of the link pins, sampler far faster than link
        st_next.sync1     = {link_frame_i, link_strobe_i, link_data_i};
        st_next.sync2     = st_reg.sync1;
        st_next.strb_prev = st_reg.sync2[1];
        frame    = st_reg.sync2[2];
        din      = st_reg.sync2[0];
        bit_rise = st_reg.sync2[1] & ~st_reg.strb_prev;

        // Receiver phases
        unique case (st_reg.rx)
            RX_HUNT:
            begin
                // Wait for a frame to open
                if (frame)
                begin
                    st_next.rx  = RX_COPY1;
                    st_next.cnt = '0;
                end
            end
            RX_COPY1:
            begin
                if (!frame)
                    st_next.rx = RX_HUNT;
                else if (bit_rise)
                begin
                    // Collect 24 bits of the first copy
                    st_next.first = {st_reg.first[WORD_W-2:0], din};
                    st_next.cnt   = st_reg.cnt + 5'h01;
                    if (st_reg.cnt == LAST_BIT)
                    begin
                        st_next.rx  = RX_COPY2;
                        st_next.cnt = '0;
                    end
                end
            end
            RX_COPY2:
            begin
                if (!frame)
                    st_next.rx = RX_HUNT;
                else if (bit_rise)
                begin
                    // Collect the second copy, compare at its last bit
                    full2          = {st_reg.second[WORD_W-2:0], din};
                    st_next.second = full2;
                    st_next.cnt    = st_reg.cnt + 5'h01;
                    if (st_reg.cnt == LAST_BIT)
                    begin
                        st_next.rx = RX_DONE;
                        if (full2 == st_reg.first)
                            verify = 1'b1;
                        else
                            st_next.mism = 1'b1;
                    end
                end
            end
            RX_DONE:
            begin
                // Hold until the frame closes
                if (!frame)
                    st_next.rx = RX_HUNT;
            end
        endcase

        // Loader takes the waiting word
        if (st_reg.pend_v && ld_ready)
            st_next.pend_v = 1'b0;

        // Route a verified word to one unit only
        w   = st_reg.first;
        idx = w.payload[IDX_W-1:0];
        if (verify)
        begin
            unique case (w.dest)
                DEST_LOADER:
                begin
                    // Park the word for the loader, refuse if one waits
                    if (st_next.pend_v)
                        st_next.rej = 1'b1;
                    else
                    begin
                        st_next.pend_v = 1'b1;
                        st_next.pend   = w;
                    end
                end
                DEST_POWER:
                begin
                    // Voltage adjust or supply switching
                    if (w.payload[PWR_OP_BIT])
                        st_next.sw = switch_apply(st_reg.sw, w.payload);
                    else
                        st_next.volt = w.payload[PWR_VOLT_W-1:0];
                    exec_conf = 1'b1;
                end
                DEST_CONTROL:
                begin
                    // Drive one relay discrete
                    if (32'(idx) < NUM_RELAYS)
                    begin
                        st_next.relay[idx] = w.payload[CTL_STATE_BIT];
                        exec_conf = 1'b1;
                    end
                    else
                        st_next.rej = 1'b1;
                end
                default:
                begin
                    // Unassigned destination code
                    st_next.rej = 1'b1;
                end
            endcase
        end

        // Confirmations: direct execution first, loader one when free
        if (exec_conf)
        begin
            st_next.conf.valid = 1'b1;
            st_next.conf.word  = w;
        end
        else if (st_reg.ldc_v)
        begin
            st_next.conf.valid = 1'b1;
            st_next.conf.word  = st_reg.ldc;
            st_next.ldc_v      = 1'b0;
        end
        // Loader finishing sets the owed flag, wins over the clear
        if (ld_done)
        begin
            st_next.ldc_v = 1'b1;
            st_next.ldc   = ld_done_word;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_reg      <= '0;
            st_reg.rx   <= RX_HUNT;
            st_reg.volt <= PWR_VOLT_RST;
            st_reg.sw   <= PWR_SW_RST;
        end
        else
            st_reg <= st_next;
    end

    assign power_volt_o   = st_reg.volt;
    assign power_switch_o = st_reg.sw;
    assign relay_o        = st_reg.relay;
    assign confirm_o      = st_reg.conf;
    assign mismatch_o     = st_reg.mism;
    assign reject_o       = st_reg.rej;

endmodule

// [tb/pcwd_link_src.sv]
/*
 * Link sender model: sends one duplicated word pair per go pulse.
 * Assumes one shared clock; signals change 1 ns after a rising edge.
 */
`timescale 1ns/1ns
module pcwd_link_src
(
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic [47:0] pair_i,
    output logic             data_o,
    output logic             strobe_o,
    output logic             frame_o,
    output logic             busy_o
);
    int i;  // Bit index, MSB first

    // Frame of 48 bits, copy one then copy two
    initial
    begin
        data_o = 1'b0;
        strobe_o = 1'b0;
        frame_o = 1'b0;
        busy_o = 1'b0;
        forever
        begin
            @(posedge clk_i);
            if (go_i)
            begin
                #1 busy_o = 1'b1;
                frame_o = 1'b1;
                for (i = 47; i >= 0; i--)
                begin
                    data_o = pair_i[i];
                    repeat (4) @(posedge clk_i);
                    #1 strobe_o = 1'b1;
                    repeat (4) @(posedge clk_i);
                    #1 strobe_o = 1'b0;
                end
                // Released line shows the inverse, never a stale bit
                frame_o = 1'b0;
                data_o = ~data_o;
                repeat (4) @(posedge clk_i);
                #1 busy_o = 1'b0;
            end
        end
    end
endmodule

// [tb/pcwd_dispatcher_chk.sv]
/*
 * Port checker for the dispatcher.
 * Assumes the dispatcher ports and one clock domain.
 */
`timescale 1ns/1ns
module pcwd_dispatcher_chk
    import pcwd_pkg::*;
#(
    parameter int unsigned SEQ_BIT_CYCLES = pcwd_pkg::SEQ_BIT_CYCLES,
    parameter int unsigned NUM_RELAYS     = pcwd_pkg::CTL_RELAYS
)
(
    input wire logic                  clk_i,
    input wire logic                  rst_n_i,
    input wire logic                  seq_clk_o,
    input wire logic                  seq_data_o,
    input wire logic [PWR_VOLT_W-1:0] power_volt_o,
    input wire logic [PWR_SW_W-1:0]   power_switch_o,
    input wire logic [NUM_RELAYS-1:0] relay_o,
    input wire pcwd_confirm_t         confirm_o,
    input wire logic                  mismatch_o,
    input wire logic                  reject_o
);
    logic [31:0] hi_cnt_reg;  // Cycles the sequencer clock stood high

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // Count high phase of the sequencer clock
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            hi_cnt_reg <= 32'h00000000;
        else
            hi_cnt_reg <= seq_clk_o ? hi_cnt_reg + 32'h00000001 : 32'h00000000;
    end

    drop_quiet_a: assert property (mismatch_o |-> $stable(power_volt_o) && $stable(power_switch_o)
        && $stable(relay_o)) else $error("dropped word changed an output");
    reject_quiet_a: assert property (reject_o |-> $stable(power_volt_o) && $stable(relay_o))
        else $error("rejected word changed an output");
    dest_legal_a: assert property (confirm_o.valid |-> confirm_o.word.dest != 2'h3)
        else $error("confirm for unassigned destination");
    volt_set_a: assert property ($changed(power_volt_o) |-> confirm_o.valid
        && confirm_o.word.dest == DEST_POWER && !confirm_o.word.payload[PWR_OP_BIT]
        && power_volt_o == confirm_o.word.payload[11:0]) else $error("voltage change not confirmed");
    switch_set_a: assert property ($changed(power_switch_o) |-> confirm_o.valid
        && confirm_o.word.dest == DEST_POWER && power_switch_o == (confirm_o.word.payload[PWR_SW_ON_BIT]
        ? ($past(power_switch_o) | confirm_o.word.payload[7:0]) : ($past(power_switch_o)
        & ~confirm_o.word.payload[7:0]))) else $error("switch change wrong or unconfirmed");
    relay_set_a: assert property ($changed(relay_o) |-> confirm_o.valid && confirm_o.word.dest
        == DEST_CONTROL && relay_o[confirm_o.word.payload[4:0]] == confirm_o.word.payload[CTL_STATE_BIT])
        else $error("relay change wrong or unconfirmed");
    seq_hold_a: assert property (seq_clk_o && $past(seq_clk_o) |-> $stable(seq_data_o))
        else $error("sequencer data moved while clock high");
    seq_half_a: assert property ($fell(seq_clk_o) |-> hi_cnt_reg == SEQ_BIT_CYCLES / 2)
        else $error("sequencer clock high phase wrong length");
endmodule

bind pcwd_dispatcher pcwd_dispatcher_chk #(.SEQ_BIT_CYCLES(SEQ_BIT_CYCLES), .NUM_RELAYS(NUM_RELAYS)) u_chk
(
    .clk_i(clk_i), .rst_n_i(rst_n_i), .seq_clk_o(seq_clk_o), .seq_data_o(seq_data_o),
    .power_volt_o(power_volt_o), .power_switch_o(power_switch_o), .relay_o(relay_o),
    .confirm_o(confirm_o), .mismatch_o(mismatch_o), .reject_o(reject_o)
);

// [tb/pcwd_dispatcher_bench.sv]
/*
 * Self-checking bench for the dispatcher.
 * Assumes the link sender model; 125 MHz clock, short loader bit time.
 */
`timescale 1ns/1ns
module pcwd_dispatcher_bench;
    import pcwd_pkg::*;
    localparam int unsigned SEQ_CYC = 40;  // Short loader bit time; a 24-bit load still outlasts one link pair
    logic          clk_i;
    logic          rst_n_i = 1'b0;
    logic          go = 1'b0;
    logic [47:0]   pair = 48'h0;
    logic          busy;
    logic          l_data;
    logic          l_strobe;
    logic          l_frame;
    logic          seq_clk;
    logic          seq_data;
    logic [11:0]   volt;
    logic [7:0]    sw;
    logic [31:0]   relay;
    pcwd_confirm_t conf;
    logic          mis;
    logic          rej;
    logic [23:0]   seq_sh = 24'h0;  // Bits caught on sequencer clock rise
    logic [23:0]   last_w = 24'h0;  // Last confirmed word
    logic          seq_prev = 1'b0;
    int            fails = 0;
    int            checks = 0;
    int            n_conf = 0;
    int            n_mis = 0;
    int            n_rej = 0;
    int            seq_n = 0;

    // Clock, 8 ns period
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    pcwd_link_src u_src (.clk_i(clk_i), .go_i(go), .pair_i(pair), .data_o(l_data),
        .strobe_o(l_strobe), .frame_o(l_frame), .busy_o(busy));

    pcwd_dispatcher #(.SEQ_BIT_CYCLES(SEQ_CYC), .NUM_RELAYS(32)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .link_data_i(l_data), .link_strobe_i(l_strobe), .link_frame_i(l_frame), .seq_clk_o(seq_clk),
        .seq_data_o(seq_data), .power_volt_o(volt), .power_switch_o(sw), .relay_o(relay),
        .confirm_o(conf), .mismatch_o(mis), .reject_o(rej));

    // Output monitor on the settled falling edge
    always @(negedge clk_i)
    begin
        if (conf.valid === 1'b1)
        begin
            n_conf++;
            last_w = conf.word;
        end
        if (mis === 1'b1)
            n_mis++;
        if (rej === 1'b1)
            n_rej++;
        if (seq_clk === 1'b1 && seq_prev === 1'b0)
        begin
            seq_sh = {seq_sh[22:0], seq_data};
            seq_n++;
        end
        seq_prev = seq_clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One word pair over the link, then a settle time
    task automatic xfer(input logic [23:0] a, input logic [23:0] b, input int w);
        @(posedge clk_i);
        #1 pair = {a, b};
        go = 1'b1;
        @(posedge clk_i);
        #1 go = 1'b0;
        @(posedge clk_i);
        while (busy) @(posedge clk_i);
        repeat (w) @(posedge clk_i);
    endtask

    task automatic t_power;
        int c;
        c = n_conf;
        xfer(24'h400ABC, 24'h400ABC, 4);
        chk("volt", 32'h00000ABC, {20'h0, volt});
        xfer(24'h6001A5, 24'h6001A5, 4);
        xfer(24'h600005, 24'h600005, 4);
        chk("switch", 32'h000000A0, {24'h0, sw});
        chk("confirms", c + 3, n_conf);
        chk("confirm word", 32'h00600005, {8'h0, last_w});
        $display("power test done");
    endtask

    task automatic t_relay;
        xfer(24'h80003F, 24'h80003F, 4);
        xfer(24'h800020, 24'h800020, 4);
        xfer(24'h80001F, 24'h80001F, 4);
        chk("relays", 32'h00000001, relay);
        $display("relay test done");
    endtask

    task automatic t_mismatch;
        int c;
        int m;
        c = n_conf;
        m = n_mis;
        xfer(24'h400555, 24'h400554, 4);
        chk("mismatch", m + 1, n_mis);
        chk("no confirm", c, n_conf);
        chk("volt kept", 32'h00000ABC, {20'h0, volt});
        $display("mismatch test done");
    endtask

    task automatic t_reject;
        int c;
        int r;
        c = n_conf;
        r = n_rej;
        xfer(24'hC00000, 24'hC00000, 4);
        chk("reject", r + 1, n_rej);
        chk("no confirm", c, n_conf);
        $display("reject test done");
    endtask

    task automatic t_loader;
        int c;
        c = n_conf;
        seq_n = 0;
        xfer(24'h123456, 24'h123456, 24 * SEQ_CYC + 40);
        chk("seq bits", 32'd24, seq_n);
        chk("seq word", 32'h00123456, {8'h0, seq_sh});
        chk("confirms", c + 1, n_conf);
        chk("confirm word", 32'h00123456, {8'h0, last_w});
        $display("loader test done");
    endtask

    // Loader busy and slot full: third loader word refused, two confirmed
    task automatic t_slot;
        int c;
        int r;
        c = n_conf;
        r = n_rej;
        xfer(24'h0A0A0A, 24'h0A0A0A, 0);
        xfer(24'h155555, 24'h155555, 0);
        xfer(24'h2AAAAA, 24'h2AAAAA, 48 * SEQ_CYC);
        chk("slot reject", r + 1, n_rej);
        chk("slot confirms", c + 2, n_conf);
        chk("slot last word", 32'h00155555, {8'h0, last_w});
        $display("slot test done");
    endtask

    task automatic close_out;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        t_power;
        t_relay;
        t_mismatch;
        t_reject;
        t_loader;
        t_slot;
        close_out;
    end

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk_i);
        fails++;
        $display("[ERR] run length expected done seen hang");
        close_out;
    end
endmodule
